// File: include/lpdm_regs.svh
`ifndef LPDM_REGS_SVH
`define LPDM_REGS_SVH

// pixel period and quarter slots of the pixel
`define LPDM_PIXEL_PERIOD_PS   15000
`define LPDM_QUARTERS          4
`define LPDM_QCNT_LAST         2'h3
// level codes
`define LPDM_CODE_OFF_FULL     3'h0
`define LPDM_CODE_OFF_75       3'h1
`define LPDM_CODE_OFF_50       3'h2
`define LPDM_CODE_OFF_25       3'h3
`define LPDM_CODE_ON_25        3'h4
`define LPDM_CODE_ON_50        3'h5
`define LPDM_CODE_ON_75        3'h6
`define LPDM_CODE_ON_FULL      3'h7
// position of the level code inside a 4-bit pixel word
`define LPDM_CODE_LSB          0
`define LPDM_WORD_W            4
// reset values
`define LPDM_RST_CODE          3'h0
`define LPDM_RST_QCNT          2'h0

`endif

// File: include/lpdm_pkg.sv
package lpdm_pkg;
	typedef logic [2:0] lpdm_code_t;
	typedef logic [1:0] lpdm_quarter_t;
	typedef logic [7:0] lpdm_wave_t;
endpackage

// File: hw/lpdm_modulator.sv
`timescale 1ns/1ps
`include "lpdm_regs.svh"

module lpdm_modulator
	import lpdm_pkg::*;
#(
	parameter int WORD_W  = `LPDM_WORD_W,
	parameter int CODE_LSB = `LPDM_CODE_LSB,
	parameter bit BLANK_ON_CHANGE = 1'b1
)(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              clk_en,
	input  wire logic [WORD_W-1:0] pixel_word,
	input  wire logic              pixel_valid,
	output logic                   pixel_ready,
	output logic                   laser_out,
	output logic                   pixel_start,
	output logic                   underrun
);

	// ---------------- slot timing ----------------
	// the clock runs at four pixel rates, one 3.75 ns slot per quarter pixel; the slot counter
	// advances on every clk_en edge from reset and holds while clk_en is low, so pixel boundaries never depend on the data supply
	lpdm_quarter_t     qcnt;
	lpdm_quarter_t     next_qcnt;
	logic              pixel_end;

	// ---------------- two-entry buffer ----------------
	logic [WORD_W-1:0] buf_data [2];
	logic [WORD_W-1:0] next_buf_data0;
	logic [WORD_W-1:0] next_buf_data1;
	logic [1:0]        buf_cnt;
	logic [1:0]        next_buf_cnt;
	logic              next_pixel_ready;
	logic              buf_empty;
	logic              buf_wr;
	logic              buf_out_valid;
	logic              buf_out_ready;
	logic              buf_rd;

	// ---------------- waveforms and selector ----------------
	logic              true_ph;
	logic              quarter_cycle_delayed_clock;
	lpdm_wave_t        cand;
	logic              selected;
	logic              next_laser;

	// ---------------- pixel state ----------------
	lpdm_code_t        code;
	lpdm_code_t        next_code;
	lpdm_code_t        fetched;
	logic              code_change;
	logic              blank;
	logic              next_blank;
	logic              next_underrun;
	logic              next_pixel_start;

	assign pixel_end = (qcnt == `LPDM_QCNT_LAST);

	always_comb begin
		next_qcnt = qcnt + 2'h1;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			qcnt <= `LPDM_RST_QCNT;
		end else if (clk_en) begin
			qcnt <= next_qcnt;
		end
	end

	// input side: a word moves when it is offered and the buffer has room
	assign buf_wr        = pixel_valid && pixel_ready;
	assign buf_empty     = (buf_cnt == 2'h0);
	// output side: the pixel sequencer consumes only on the last slot of a pixel
	assign buf_out_valid = !buf_empty;
	assign buf_out_ready = pixel_end;
	assign buf_rd        = buf_out_valid && buf_out_ready;
	assign fetched       = buf_data[0][CODE_LSB +: 3];

	always_comb begin
		next_buf_data0 = buf_data[0];
		next_buf_data1 = buf_data[1];
		next_buf_cnt   = buf_cnt;
		case ({buf_wr, buf_rd})
			2'b10: begin
				if (buf_empty) begin
					next_buf_data0 = pixel_word;
				end else begin
					next_buf_data1 = pixel_word;
				end
				next_buf_cnt = buf_cnt + 2'h1;
			end
			2'b01: begin
				next_buf_data0 = buf_data[1];
				next_buf_cnt   = buf_cnt - 2'h1;
			end
			2'b11: begin
				// ready is low when full, so this only happens with one or zero held; zero never reads
				next_buf_data0 = pixel_word;
			end
			default: begin
				next_buf_cnt = buf_cnt;
			end
		endcase
		// ready is registered, so it drops in the same step that makes the buffer full
		next_pixel_ready = (next_buf_cnt != 2'h2);
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			buf_data[0] <= '0;
			buf_data[1] <= '0;
			buf_cnt     <= 2'h0;
			pixel_ready <= 1'b0;
		end else if (clk_en) begin
			buf_data[0] <= next_buf_data0;
			buf_data[1] <= next_buf_data1;
			buf_cnt     <= next_buf_cnt;
			pixel_ready <= next_pixel_ready;
		end
	end

	// ---------------- candidate waveforms ----------------
	// slots of one pixel, slot 0 first, for codes 0 to 7:
	// 0000, 0001, 0011, 0111, 1000, 1100, 1110, 1111
	// true phase is high in slots 0-1, the quarter-delayed phase in slots 1-2
	assign true_ph                     = (qcnt == 2'h0) || (qcnt == 2'h1);
	assign quarter_cycle_delayed_clock = (qcnt == 2'h1) || (qcnt == 2'h2);

	// each partial level is one gate: delayed phase or true/inverted phase, inverted or not;
	// bit n of a mask belongs to level code n, codes 0 and 7 take no gate
	localparam lpdm_wave_t GATE_USE_DLY = 8'h5a;
	localparam lpdm_wave_t GATE_INV_REF = 8'h18;
	localparam lpdm_wave_t GATE_INV_OUT = 8'h16;

	assign cand[`LPDM_CODE_OFF_FULL] = 1'b0;
	assign cand[`LPDM_CODE_ON_FULL]  = 1'b1;

	for (genvar gi = 1; gi < 7; gi++) begin : g_gate
		logic ref_in;
		logic dly_in;
		assign ref_in   = GATE_INV_REF[gi] ^ true_ph;
		assign dly_in   = GATE_USE_DLY[gi] & quarter_cycle_delayed_clock;
		assign cand[gi] = GATE_INV_OUT[gi] ^ (dly_in | ref_in);
	end

	// 8:1 selector: every candidate stays live and only the addressed one passes
	always_comb begin
		case (code)
			`LPDM_CODE_OFF_FULL: selected = cand[`LPDM_CODE_OFF_FULL];
			`LPDM_CODE_OFF_75:   selected = cand[`LPDM_CODE_OFF_75];
			`LPDM_CODE_OFF_50:   selected = cand[`LPDM_CODE_OFF_50];
			`LPDM_CODE_OFF_25:   selected = cand[`LPDM_CODE_OFF_25];
			`LPDM_CODE_ON_25:    selected = cand[`LPDM_CODE_ON_25];
			`LPDM_CODE_ON_50:    selected = cand[`LPDM_CODE_ON_50];
			`LPDM_CODE_ON_75:    selected = cand[`LPDM_CODE_ON_75];
			`LPDM_CODE_ON_FULL:  selected = cand[`LPDM_CODE_ON_FULL];
			default:             selected = 1'b0;
		endcase
	end

	// ---------------- pixel sequencing ----------------
	// a reload with another code is a reselection, whose first slot may carry a selector glitch
	assign code_change = (fetched != code);

	always_comb begin
		next_code        = code;
		next_blank       = 1'b0;
		next_underrun    = 1'b0;
		next_pixel_start = 1'b0;
		if (pixel_end) begin
			// every boundary is marked, also one that repeats the old level
			next_pixel_start = 1'b1;
			if (buf_rd) begin
				next_code  = fetched;
				next_blank = BLANK_ON_CHANGE && code_change;
			end else begin
				// starved: keep the old level rather than emit garbage, and flag it
				next_underrun = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			code        <= `LPDM_RST_CODE;
			blank       <= 1'b0;
			underrun    <= 1'b0;
			pixel_start <= 1'b0;
		end else if (clk_en) begin
			code        <= next_code;
			blank       <= next_blank;
			underrun    <= next_underrun;
			pixel_start <= next_pixel_start;
		end
	end

	// ---------------- laser output ----------------
	// the head sees a registered copy of the selector, so select changes settle a slot before use
	always_comb begin
		next_laser = blank ? 1'b0 : selected;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			laser_out <= 1'b0;
		end else if (clk_en) begin
			laser_out <= next_laser;
		end
	end

endmodule

// File: test/lpdm_modulator_properties.sv
`timescale 1ns/1ps
module lpdm_modulator_properties #(
	parameter int WORD_W = 4
)(
	input wire logic              clock,
	input wire logic              rst,
	input wire logic              clk_en,
	input wire logic [WORD_W-1:0] pixel_word,
	input wire logic              pixel_valid,
	input wire logic              pixel_ready,
	input wire logic              laser_out,
	input wire logic              pixel_start,
	input wire logic              underrun
);
	// k mirrors the quarter slot, occ the buffer fill, both counted on enabled edges only
	logic [1:0] k, occ;
	logic       run, got;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			k <= 2'h0;
			occ <= 2'h0;
			run <= 1'b0;
			got <= 1'b0;
		end else if (clk_en) begin
			k <= k + 2'h1;
			occ <= occ + 2'(pixel_valid && pixel_ready) - 2'(k == 2'h3 && occ != 2'h0);
			run <= 1'b1;
			got <= got | pixel_start;
		end
	end
	sequence s_load;
		k == 2'h3 && clk_en && occ != 2'h0;
	endsequence
	sequence s_starve;
		k == 2'h3 && clk_en && run && occ == 2'h0;
	endsequence
	a_load_start: assert property (s_load |=> pixel_start && !underrun) else $error("word not loaded");
	a_starve_flag: assert property (s_starve |=> underrun && pixel_start) else $error("no underrun");
	a_start_slot: assert property (pixel_start || underrun |-> k == 2'h0) else $error("boundary off slot");
	a_pixel_mark: assert property (run && k == 2'h0 |-> pixel_start) else $error("no mark");
	a_start_pulse: assert property (pixel_start && clk_en |=> !pixel_start) else $error("start too long");
	a_ready_room: assert property (run |-> pixel_ready == (occ != 2'h2)) else $error("ready wrong");
	a_dark_reset: assert property (!got |-> !laser_out) else $error("laser lit early");
	a_freeze_hold: assert property (!clk_en |=> $stable({laser_out, pixel_start, pixel_ready, underrun}))
		else $error("moved while frozen");
endmodule
bind lpdm_modulator lpdm_modulator_properties #(.WORD_W(WORD_W)) u_props (.clock(clock), .rst(rst),
	.clk_en(clk_en), .pixel_word(pixel_word), .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
	.laser_out(laser_out), .pixel_start(pixel_start), .underrun(underrun));

// File: test/lpdm_pixel_source.sv
`timescale 1ns/1ps
module lpdm_pixel_source (
	input wire logic   clock,
	input wire logic   rst,
	input wire logic   clk_en,
	input wire logic   pixel_ready,
	output logic [3:0] pixel_word,
	output logic       pixel_valid
);
	int   n = 0;
	logic t;
	initial pixel_valid = 1'b0;
	initial pixel_word = 4'h0;
	always @(posedge clock) begin
		t = clk_en && pixel_valid && pixel_ready;
		#2;
		n += int'(t);
		if (t || !pixel_valid) begin
			// supply ends after 40 words so the buffer drains and underruns
			pixel_valid = !rst && n < 40 && $urandom_range(3) != 0;
			pixel_word = pixel_valid ? {1'($urandom), n < 8 ? 3'(n) : 3'($urandom)} : ~pixel_word;
		end
	end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       clk_en = 1'b0;
	logic [3:0] pixel_word;
	logic       pixel_valid, pixel_ready, laser_out, pixel_start, underrun, en_q;
	int         n_errors = 0;
	int         num_checks = 0;
	int         q[$];
	int         cnt = 0, e = 0, code, last = 0, cyc = 0, n_under = 0;
	logic [3:0] hi = 4'h0;
	always #12.5 clock = ~clock;
	lpdm_modulator dut (.clock(clock), .rst(rst), .clk_en(clk_en), .pixel_word(pixel_word),
		.pixel_valid(pixel_valid), .pixel_ready(pixel_ready), .laser_out(laser_out),
		.pixel_start(pixel_start), .underrun(underrun));
	lpdm_pixel_source src (.clock(clock), .rst(rst), .clk_en(clk_en), .pixel_ready(pixel_ready),
		.pixel_word(pixel_word), .pixel_valid(pixel_valid));
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clock) begin
		en_q <= clk_en;
		if (!rst && clk_en && pixel_valid && pixel_ready) q.push_back(int'(pixel_word[2:0]));
		if (++cyc > 2000) begin
			n_errors++;
			close_out();
		end
	end
	// the head samples mid-slot, so select changes are masked; slot0 of a changed level is blanked
	always @(negedge clock) if (!rst && en_q) begin
		if (cnt > 0) begin
			hi = hi + 4'(laser_out);
			if (--cnt == 0) check("laser high slots", hi, 4'(e));
		end
		if (pixel_start) begin
			check("load without word", 4'(!underrun && q.size() == 0), 4'h0);
			code = (underrun || q.size() == 0) ? last : q.pop_front();
			e = code < 4 ? code : code - 3 - int'(code != last);
			last = code;
			cnt = 4;
			hi = 4'h0;
		end
		n_under += int'(underrun);
	end
	initial begin
		void'($urandom(32'hb5bd29b6));
		repeat (16) @(posedge clock);
		#2 rst = 1'b0;
		repeat (900) begin
			@(posedge clock);
			#2 clk_en = $urandom_range(7) != 0;
		end
		check("words left", 4'(q.size()), 4'h0);
		check("underrun seen", 4'(n_under != 0), 4'h1);
		close_out();
	end
endmodule
